// ===== bench/slpm_asserts.sv
// Concurrent checks on the ports of the counter block.
`default_nettype none

module slpm_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic frame_strobe_i,
    input wire logic [slpm_pkg::B1_W-1:0] b1_err_i,
    input wire logic [slpm_pkg::ERR_W-1:0] b2_err_i,
    input wire logic sef_defect_i,
    input wire logic ais_l_defect_i,
    input wire logic ais_l_failure_i,
    input wire logic lower_failure_i,
    input wire logic one_sec_tick_i,
    input wire logic period_tick_i,
    input wire logic revertive_i,
    input wire logic service_on_protect_i,
    input wire logic [slpm_pkg::CNT_W-1:0] section_code_violation_count_o,
    input wire logic [slpm_pkg::CNT_W-1:0] section_errored_seconds_o,
    input wire logic [slpm_pkg::CNT_W-1:0] severe_frame_error_seconds_o,
    input wire logic [slpm_pkg::CNT_W-1:0] line_code_violation_count_o,
    input wire logic [slpm_pkg::CNT_W-1:0] line_severe_errored_seconds_o,
    input wire logic [slpm_pkg::CNT_W-1:0] line_unavailable_seconds_o,
    input wire logic [slpm_pkg::CNT_W-1:0] line_failure_event_count_o,
    input wire logic [slpm_pkg::CNT_W-1:0] protection_switch_count_o,
    input wire logic [slpm_pkg::CNT_W-1:0] protection_switch_duration_o,
    input wire logic line_unavailable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fail_lvl;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    // Either failure source forms the line failure.
    assign fail_lvl = ais_l_failure_i | lower_failure_i;

    // Limits a per-frame result to what one frame can carry.
    function automatic logic [31:0] clip(input logic [31:0] v, input logic [31:0] m);
        return (v > m) ? m : v;
    endfunction

    // A second closed with a frame defect, then one settling cycle.
    sequence s_sef_close;
        (ce_i && one_sec_tick_i && sef_defect_i && !period_tick_i) ##1 (ce_i && !period_tick_i);
    endsequence
    // A second closed with line alarm, then one settling cycle.
    sequence s_ais_close;
        (ce_i && one_sec_tick_i && ais_l_defect_i && !period_tick_i) ##1 (ce_i && !period_tick_i);
    endsequence

    a_section_cv_step: assert property (
        ce_i && frame_strobe_i && !period_tick_i |=> section_code_violation_count_o ==
        $past(section_code_violation_count_o) + clip(32'($past(b1_err_i)), 32'(slpm_pkg::B1_MAX))
    ) else $error("Section violation count step is wrong.");
    a_line_cv_step: assert property (
        ce_i && frame_strobe_i && !period_tick_i |=> line_code_violation_count_o ==
        $past(line_code_violation_count_o) + clip(32'($past(b2_err_i)), 32'(slpm_pkg::B2_MAX))
    ) else $error("Line violation count step is wrong.");
    a_frame_sec_step: assert property (
        ce_i && one_sec_tick_i && sef_defect_i && !period_tick_i |=>
        severe_frame_error_seconds_o == $past(severe_frame_error_seconds_o) + 32'h1
    ) else $error("Frame defect second not counted.");
    a_section_es_step: assert property (
        s_sef_close |=> section_errored_seconds_o == $past(section_errored_seconds_o, 2) + 32'h1
    ) else $error("Section errored second not counted.");
    a_line_ses_step: assert property (
        s_ais_close |=>
        line_severe_errored_seconds_o == $past(line_severe_errored_seconds_o, 2) + 32'h1
    ) else $error("Line severe second not counted.");
    a_unavail_entry_ten: assert property (
        ce_i && !period_tick_i && $rose(line_unavailable_o) |=>
        line_unavailable_seconds_o == $past(line_unavailable_seconds_o) + 32'ha
    ) else $error("Unavailable entry did not add ten seconds.");
    a_fail_event_once: assert property (
        ce_i && !period_tick_i && $past(ce_i) && $past(rst_b_i) && fail_lvl && !$past(fail_lvl)
        |=> line_failure_event_count_o == $past(line_failure_event_count_o) + 32'h1
    ) else $error("Failure event not counted at onset.");
    a_switch_step: assert property (
        ce_i && !period_tick_i && revertive_i && $past(ce_i) && $past(rst_b_i) &&
        service_on_protect_i != $past(service_on_protect_i)
        |=> protection_switch_count_o == $past(protection_switch_count_o) + 32'h1
    ) else $error("Service transfer not counted.");
    a_switch_frozen: assert property (
        ce_i && !period_tick_i && !revertive_i |=> $stable(protection_switch_count_o)
    ) else $error("Switch count moved without revertive mode.");
    a_duration_step: assert property (
        ce_i && one_sec_tick_i && revertive_i && service_on_protect_i && !period_tick_i |=>
        protection_switch_duration_o == $past(protection_switch_duration_o) + 32'h1
    ) else $error("Protection second not counted.");
endmodule

bind slpm_top slpm_asserts slpm_asserts_i (.*);

`default_nettype wire

// ===== bench/slpm_line_model.sv
// Incoming line model that delivers frames with parity error counts.
`default_nettype none

module slpm_line_model (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic go_i,
    input wire logic [slpm_pkg::B1_W-1:0] b1_req_i,
    input wire logic [slpm_pkg::ERR_W-1:0] b2_req_i,
    output logic frame_strobe_o,
    output logic [slpm_pkg::B1_W-1:0] b1_err_o,
    output logic [slpm_pkg::ERR_W-1:0] b2_err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;

    // A frame every third cycle; between frames the counts toggle as junk.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || phase == 2'h2) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
        frame_strobe_o <= rst_b_i && go_i && phase == 2'h0;
        if (!rst_b_i) begin
            b1_err_o <= 4'h5;
            b2_err_o <= 5'h0a;
        end else if (go_i && phase == 2'h0) begin
            b1_err_o <= b1_req_i;
            b2_err_o <= b2_req_i;
        end else begin
            b1_err_o <= ~b1_err_o;
            b2_err_o <= ~b2_err_o;
        end
    end
endmodule

`default_nettype wire

// ===== bench/slpm_tb.sv
// Self-checking bench for the section and line counter block.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_b_i, ce_i, one_sec_tick_i, period_tick_i, go;
    logic frame_strobe_i, sef_defect_i, los_defect_i, ais_l_defect_i;
    logic ais_l_failure_i, lower_failure_i, revertive_i, service_on_protect_i;
    logic [slpm_pkg::B1_W-1:0] b1_err_i, b1_req;
    logic [slpm_pkg::ERR_W-1:0] b2_err_i, b2_req;
    logic [slpm_pkg::K_W-1:0] section_k_i, line_k_i;
    logic [slpm_pkg::CNT_W-1:0] section_code_violation_count_o, section_errored_seconds_o;
    logic [slpm_pkg::CNT_W-1:0] section_severe_errored_seconds_o, severe_frame_error_seconds_o;
    logic [slpm_pkg::CNT_W-1:0] line_code_violation_count_o, line_errored_seconds_o;
    logic [slpm_pkg::CNT_W-1:0] line_severe_errored_seconds_o, line_unavailable_seconds_o;
    logic [slpm_pkg::CNT_W-1:0] line_failure_event_count_o, protection_switch_count_o;
    logic [slpm_pkg::CNT_W-1:0] protection_switch_duration_o, switch_count_working_variant_o;
    logic [slpm_pkg::CNT_W-1:0] switch_count_span_variant_o, switch_count_ring_variant_o;
    logic [slpm_pkg::CNT_W-1:0] switch_duration_working_variant_o;
    logic [slpm_pkg::CNT_W-1:0] switch_duration_span_variant_o, switch_duration_ring_variant_o;
    logic line_unavailable_o;
    int fails = 0;
    int num_checks = 0;
    int nfr = 0;

    slpm_top slpm_top_i (.*);
    slpm_line_model slpm_line_model_i (.clk_sys_i, .rst_b_i, .go_i(go), .b1_req_i(b1_req),
        .b2_req_i(b2_req), .frame_strobe_o(frame_strobe_i), .b1_err_o(b1_err_i),
        .b2_err_o(b2_err_i));

    // Free-running system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Counts frames that the block takes.
    always @(posedge clk_sys_i) begin
        if (rst_b_i && ce_i && frame_strobe_i) begin
            nfr <= nfr + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // One closed second (or a period start) with defects {sef, los, ais} inside it.
    task automatic sec(input logic per, input logic [2:0] d);
        @(posedge clk_sys_i);
        {sef_defect_i, los_defect_i, ais_l_defect_i} <= d;
        @(posedge clk_sys_i);
        period_tick_i <= per;
        one_sec_tick_i <= !per;
        @(posedge clk_sys_i);
        {sef_defect_i, los_defect_i, ais_l_defect_i} <= 3'h0;
        period_tick_i <= 1'b0;
        one_sec_tick_i <= 1'b0;
        wt(5);
        @(negedge clk_sys_i);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_parity();
        int n;
        sec(1'b1, 3'h0);
        nfr = 0;
        @(posedge clk_sys_i);
        b1_req <= 4'h9;
        b2_req <= 5'h19;
        go <= 1'b1;
        wt(12);
        go <= 1'b0;
        wt(3);
        @(negedge clk_sys_i);
        n = nfr;
        chk(section_code_violation_count_o, 32'(8 * n));
        chk(line_code_violation_count_o, 32'(24 * n));
        @(posedge clk_sys_i);
        section_k_i <= 20'(8 * n);
        line_k_i <= 20'(24 * n + 1);
        ce_i <= 1'b0;
        go <= 1'b1;
        wt(9);
        go <= 1'b0;
        wt(3);
        ce_i <= 1'b1;
        sec(1'b0, 3'h0);
        chk(section_code_violation_count_o, 32'(8 * n));
        chk(section_errored_seconds_o, 32'h1);
        chk(section_severe_errored_seconds_o, 32'h1);
        chk(line_errored_seconds_o, 32'h1);
        chk(line_severe_errored_seconds_o, 32'h0);
        chk(severe_frame_error_seconds_o, 32'h0);
    endtask

    task automatic t_defects();
        sec(1'b1, 3'h0);
        sec(1'b0, 3'h4);
        chk(severe_frame_error_seconds_o, 32'h1);
        chk(section_severe_errored_seconds_o, 32'h1);
        sec(1'b0, 3'h2);
        chk(severe_frame_error_seconds_o, 32'h1);
        chk(section_errored_seconds_o, 32'h2);
        chk(line_errored_seconds_o, 32'h0);
        sec(1'b0, 3'h1);
        chk(line_errored_seconds_o, 32'h1);
        chk(line_severe_errored_seconds_o, 32'h1);
        chk(section_errored_seconds_o, 32'h2);
    endtask

    task automatic t_unavail();
        sec(1'b0, 3'h0);
        sec(1'b1, 3'h0);
        repeat (9) sec(1'b0, 3'h1);
        chk(32'(line_unavailable_o), 32'h0);
        sec(1'b0, 3'h1);
        chk(32'(line_unavailable_o), 32'h1);
        chk(line_unavailable_seconds_o, 32'ha);
        sec(1'b0, 3'h1);
        chk(line_unavailable_seconds_o, 32'hb);
        repeat (9) sec(1'b0, 3'h0);
        chk(32'(line_unavailable_o), 32'h1);
        sec(1'b0, 3'h0);
        chk(32'(line_unavailable_o), 32'h0);
        chk(line_unavailable_seconds_o, 32'hb);
    endtask

    task automatic t_failure();
        sec(1'b1, 3'h0);
        @(posedge clk_sys_i);
        ais_l_failure_i <= 1'b1;
        wt(3);
        lower_failure_i <= 1'b1;
        wt(2);
        ais_l_failure_i <= 1'b0;
        wt(2);
        @(negedge clk_sys_i);
        chk(line_failure_event_count_o, 32'h1);
        sec(1'b1, 3'h0);
        chk(line_failure_event_count_o, 32'h0);
        @(posedge clk_sys_i);
        lower_failure_i <= 1'b0;
        wt(2);
        lower_failure_i <= 1'b1;
        wt(3);
        lower_failure_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(line_failure_event_count_o, 32'h1);
    endtask

    task automatic t_protect();
        @(posedge clk_sys_i);
        revertive_i <= 1'b1;
        sec(1'b1, 3'h0);
        @(posedge clk_sys_i);
        service_on_protect_i <= 1'b1;
        sec(1'b0, 3'h0);
        @(posedge clk_sys_i);
        service_on_protect_i <= 1'b0;
        sec(1'b0, 3'h0);
        chk(protection_switch_count_o, 32'h2);
        chk(protection_switch_duration_o, 32'h2);
        @(posedge clk_sys_i);
        revertive_i <= 1'b0;
        service_on_protect_i <= 1'b1;
        sec(1'b0, 3'h0);
        @(posedge clk_sys_i);
        service_on_protect_i <= 1'b0;
        sec(1'b0, 3'h0);
        chk(protection_switch_count_o, 32'h2);
        chk(protection_switch_duration_o, 32'h2);
        chk(switch_count_working_variant_o | switch_count_span_variant_o |
            switch_count_ring_variant_o | switch_duration_working_variant_o |
            switch_duration_span_variant_o | switch_duration_ring_variant_o, 32'h0);
    endtask

    // Cuts a hung run short.
    initial begin
        wt(5000);
        fails++;
        final_report();
    end
    // Reset, then the scenarios in turn.
    initial begin
        rst_b_i = 1'b0;
        ce_i = 1'b1;
        {sef_defect_i, los_defect_i, ais_l_defect_i, ais_l_failure_i, lower_failure_i} = 5'h00;
        {one_sec_tick_i, period_tick_i, revertive_i, service_on_protect_i, go} = 5'h00;
        b1_req = 4'h0;
        b2_req = 5'h00;
        section_k_i = 20'h0_0100;
        line_k_i = 20'h0_0100;
        wt(8);
        rst_b_i <= 1'b1;
        @(negedge clk_sys_i);
        chk(line_unavailable_seconds_o, 32'h0);
        t_parity();
        t_defects();
        t_unavail();
        t_failure();
        t_protect();
        final_report();
    end
endmodule

`default_nettype wire

// ===== core/slpm_sec_acc.sv
// Current-second accumulator that qualifies errored and severe seconds.
`default_nettype none

module slpm_sec_acc (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    slpm_sec_if.acc sif
);

    typedef struct packed {
        logic [slpm_pkg::SEC_W-1:0] cv;
        logic dseen;
        logic done;
        logic es;
        logic ses;
    } slpm_acc_st_t;

    slpm_acc_st_t r;
    slpm_acc_st_t next_r;
    logic [slpm_pkg::SEC_W-1:0] sum;
    logic dsum;

    // Close the second on the tick; events in that cycle belong to it.
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        sum = r.cv + slpm_pkg::SEC_W'(sif.err);
        dsum = r.dseen | sif.defect;
        if (sif.tick) begin
            next_r.done = 1'b1;
            next_r.es = (sum != '0) | dsum;
            next_r.ses = (sum >= slpm_pkg::SEC_W'(sif.thresh)) | dsum;
            next_r.cv = '0;
            next_r.dseen = 1'b0;
        end else begin
            next_r.cv = sum;
            next_r.dseen = dsum;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else if (sif.ce) begin
            r <= next_r;
        end
    end

    assign sif.done = r.done;
    assign sif.es = r.es;
    assign sif.ses = r.ses;

endmodule

`default_nettype wire

// ===== core/slpm_top.sv
// Near-end section, line and protection performance counters.
`default_nettype none

module slpm_top (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Frame boundary; parity counts are valid with it.
    input wire logic frame_strobe_i,
    input wire logic [slpm_pkg::B1_W-1:0] b1_err_i,
    input wire logic [slpm_pkg::ERR_W-1:0] b2_err_i,
    // Defect and failure levels from the overhead logic.
    input wire logic sef_defect_i,
    input wire logic los_defect_i,
    input wire logic ais_l_defect_i,
    input wire logic ais_l_failure_i,
    input wire logic lower_failure_i,
    // Timing pulses.
    input wire logic one_sec_tick_i,
    input wire logic period_tick_i,
    // Severity thresholds for the two layers.
    input wire logic [slpm_pkg::K_W-1:0] section_k_i,
    input wire logic [slpm_pkg::K_W-1:0] line_k_i,
    // Protection configuration and state.
    input wire logic revertive_i,
    input wire logic service_on_protect_i,
    // Period counters.
    output logic [slpm_pkg::CNT_W-1:0] section_code_violation_count_o,
    output logic [slpm_pkg::CNT_W-1:0] section_errored_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] section_severe_errored_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] severe_frame_error_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] line_code_violation_count_o,
    output logic [slpm_pkg::CNT_W-1:0] line_errored_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] line_severe_errored_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] line_unavailable_seconds_o,
    output logic [slpm_pkg::CNT_W-1:0] line_failure_event_count_o,
    output logic [slpm_pkg::CNT_W-1:0] protection_switch_count_o,
    output logic [slpm_pkg::CNT_W-1:0] protection_switch_duration_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_count_working_variant_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_count_span_variant_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_count_ring_variant_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_duration_working_variant_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_duration_span_variant_o,
    output logic [slpm_pkg::CNT_W-1:0] switch_duration_ring_variant_o,
    // Line availability state.
    output logic line_unavailable_o
);

    ////////////////////////////////////////////////////////////////////////////

    // State of the top level; the accumulators and the availability tracker keep their own.
    typedef struct packed {
        logic [slpm_pkg::CNT_W-1:0] cvs;
        logic [slpm_pkg::CNT_W-1:0] ess;
        logic [slpm_pkg::CNT_W-1:0] sess;
        logic [slpm_pkg::CNT_W-1:0] sefs;
        logic [slpm_pkg::CNT_W-1:0] cvl;
        logic [slpm_pkg::CNT_W-1:0] esl;
        logic [slpm_pkg::CNT_W-1:0] sesl;
        logic [slpm_pkg::CNT_W-1:0] uasl;
        logic [slpm_pkg::CNT_W-1:0] fcl;
        logic [slpm_pkg::CNT_W-1:0] protection_switch_count;
        logic [slpm_pkg::CNT_W-1:0] protection_switch_duration;
        logic [slpm_pkg::NVAR-1:0][slpm_pkg::CNT_W-1:0] vars;
        logic sef_seen;
        logic prot_seen;
        logic prot_q;
        logic fail_q;
    } slpm_top_st_t;

    slpm_top_st_t r;
    slpm_top_st_t next_r;

    logic [slpm_pkg::B1_W-1:0] b1_clip;
    logic [slpm_pkg::ERR_W-1:0] b2_clip;
    logic [slpm_pkg::B1_W-1:0] b1_add;
    logic [slpm_pkg::ERR_W-1:0] b2_add;
    logic fail_now;
    logic sef_sec;
    logic prot_sec;
    logic [slpm_pkg::ADD_W-1:0] ua_add;

    slpm_sec_if sec_s ();
    slpm_sec_if sec_l ();

    // Clears a counter at a period boundary, then adds this cycle's count.
    function automatic logic [slpm_pkg::CNT_W-1:0] bump(
        input logic [slpm_pkg::CNT_W-1:0] c,
        input logic clr,
        input logic [slpm_pkg::CNT_W-1:0] add
    );
        logic [slpm_pkg::CNT_W-1:0] b;
        b = clr ? '0 : c;
        return b + add;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // Per-frame parity counts, clipped to what a frame can carry.
    always_comb begin
        b1_clip = (b1_err_i > slpm_pkg::B1_MAX) ? slpm_pkg::B1_MAX : b1_err_i;
        b2_clip = (b2_err_i > slpm_pkg::B2_MAX) ? slpm_pkg::B2_MAX : b2_err_i;
        b1_add = frame_strobe_i ? b1_clip : '0;
        b2_add = frame_strobe_i ? b2_clip : '0;
    end

    // Section accumulator drive.
    assign sec_s.ce = ce_i;
    assign sec_s.tick = one_sec_tick_i;
    assign sec_s.err = slpm_pkg::ERR_W'(b1_add);
    assign sec_s.defect = sef_defect_i | los_defect_i;
    assign sec_s.thresh = section_k_i;

    // Line accumulator drive.
    assign sec_l.ce = ce_i;
    assign sec_l.tick = one_sec_tick_i;
    assign sec_l.err = b2_add;
    assign sec_l.defect = ais_l_defect_i;
    assign sec_l.thresh = line_k_i;

    // Section layer current second.
    slpm_sec_acc u_acc_s (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sif(sec_s.acc)
    );

    // Line layer current second.
    slpm_sec_acc u_acc_l (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sif(sec_l.acc)
    );

    // Line availability from closed line seconds.
    slpm_unavail u_ua (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .sif(sec_l.mon),
        .add_o(ua_add),
        .unavail_o(line_unavailable_o)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Line failure level for this cycle, and qualifiers that span the current second.
    always_comb begin
        fail_now = ais_l_failure_i | lower_failure_i;
        sef_sec = r.sef_seen | sef_defect_i;
        prot_sec = r.prot_seen | service_on_protect_i;
    end

    // Next value of every counter.
    always_comb begin
        next_r = r;

        next_r.cvs = bump(r.cvs, period_tick_i, slpm_pkg::CNT_W'(b1_add));
        next_r.ess = bump(r.ess, period_tick_i,
            slpm_pkg::CNT_W'(sec_s.done & sec_s.es));
        next_r.sess = bump(r.sess, period_tick_i,
            slpm_pkg::CNT_W'(sec_s.done & sec_s.ses));

        next_r.sefs = bump(r.sefs, period_tick_i,
            slpm_pkg::CNT_W'(one_sec_tick_i & sef_sec));

        next_r.cvl = bump(r.cvl, period_tick_i, slpm_pkg::CNT_W'(b2_add));
        next_r.esl = bump(r.esl, period_tick_i,
            slpm_pkg::CNT_W'(sec_l.done & sec_l.es));
        next_r.sesl = bump(r.sesl, period_tick_i,
            slpm_pkg::CNT_W'(sec_l.done & sec_l.ses));
        next_r.uasl = bump(r.uasl, period_tick_i, slpm_pkg::CNT_W'(ua_add));

        next_r.fail_q = fail_now;
        next_r.fcl = bump(r.fcl, period_tick_i,
            slpm_pkg::CNT_W'(fail_now & ~r.fail_q));

        next_r.prot_q = service_on_protect_i;
        next_r.protection_switch_count = bump(r.protection_switch_count, period_tick_i,
            slpm_pkg::CNT_W'(revertive_i & (service_on_protect_i ^ r.prot_q)));

        next_r.protection_switch_duration = bump(r.protection_switch_duration, period_tick_i,
            slpm_pkg::CNT_W'(revertive_i & one_sec_tick_i & prot_sec));

        if (one_sec_tick_i) begin
            next_r.sef_seen = 1'b0;
            next_r.prot_seen = 1'b0;
        end else begin
            next_r.sef_seen = sef_sec;
            next_r.prot_seen = prot_sec;
        end

        next_r.vars = '0;
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Counter outputs straight from the state register.
    assign section_code_violation_count_o = r.cvs;
    assign section_errored_seconds_o = r.ess;
    assign section_severe_errored_seconds_o = r.sess;
    assign severe_frame_error_seconds_o = r.sefs;
    assign line_code_violation_count_o = r.cvl;
    assign line_errored_seconds_o = r.esl;
    assign line_severe_errored_seconds_o = r.sesl;
    assign line_unavailable_seconds_o = r.uasl;
    assign line_failure_event_count_o = r.fcl;
    assign protection_switch_count_o = r.protection_switch_count;
    assign protection_switch_duration_o = r.protection_switch_duration;

    // Ring-type variants, never incremented on this card.
    assign switch_count_working_variant_o = r.vars[0];
    assign switch_count_span_variant_o = r.vars[1];
    assign switch_count_ring_variant_o = r.vars[2];
    assign switch_duration_working_variant_o = r.vars[3];
    assign switch_duration_span_variant_o = r.vars[4];
    assign switch_duration_ring_variant_o = r.vars[5];

endmodule

`default_nettype wire

// ===== core/slpm_unavail.sv
// Line availability tracker working on closed seconds.
`default_nettype none

module slpm_unavail (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    slpm_sec_if.mon sif,
    output logic [slpm_pkg::ADD_W-1:0] add_o,
    output logic unavail_o
);

    typedef struct packed {
        slpm_pkg::slpm_ua_state_t st;
        logic [slpm_pkg::RUN_W-1:0] run;
        logic [slpm_pkg::ADD_W-1:0] add;
    } slpm_ua_st_t;

    slpm_ua_st_t r;
    slpm_ua_st_t next_r;
    logic [slpm_pkg::RUN_W-1:0] run1;

    // Seconds inside an open run are held back until the run decides them.
    always_comb begin
        next_r = r;
        next_r.add = '0;
        run1 = r.run + 4'h1;
        if (sif.done) begin
            case (r.st)
                slpm_pkg::SLPM_AVAIL: begin
                    if (!sif.ses) begin
                        next_r.run = '0;
                    end else if (run1 == slpm_pkg::UA_RUN) begin
                        next_r.st = slpm_pkg::SLPM_UNAVAIL;
                        next_r.run = '0;
                        next_r.add = slpm_pkg::ADD_W'(slpm_pkg::UA_RUN);
                    end else begin
                        next_r.run = run1;
                    end
                end
                slpm_pkg::SLPM_UNAVAIL: begin
                    if (sif.ses) begin
                        next_r.add = slpm_pkg::ADD_W'(run1);
                        next_r.run = '0;
                    end else if (run1 == slpm_pkg::UA_RUN) begin
                        next_r.st = slpm_pkg::SLPM_AVAIL;
                        next_r.run = '0;
                    end else begin
                        next_r.run = run1;
                    end
                end
                default: begin
                    next_r.st = slpm_pkg::SLPM_AVAIL;
                    next_r.run = '0;
                end
            endcase
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else if (sif.ce) begin
            r <= next_r;
        end
    end

    assign add_o = r.add;
    assign unavail_o = (r.st == slpm_pkg::SLPM_UNAVAIL);

endmodule

`default_nettype wire

// ===== inc/slpm_pkg.sv
// Shared constants and types for the section and line performance counters.
// How it works
// - Count B1 parity errors, at most eight per frame.
// - Each section violation bumps the section code count.
// - Section errored second: violation, frame defect or LOS.
// - Section severe second: violations reach K, or defect.
// - Count seconds with severe frame defect alone.
// - Count B2 parity errors, at most eight times n.
// - Each line violation bumps the line code count.
// - Line errored second: violation or line AIS.
// - Line severe second: violations reach K, or AIS.
// - Unavailable from onset of ten severe seconds.
// - Available again from onset of ten clean seconds.
// - Failure event starts on line failure, ends on clear.
// - Failure event counted only in its starting period.
// - Working card counts switches out and back.
// - Protection card counts switches out and back.
// - Switch count only under revertive line protection.
// - Working line counts seconds carried on protection.
// - Protection line counts seconds it carries service.
// - Duration count only under revertive line protection.
// - Ring, span and working variants never increment.
`default_nettype none

package slpm_pkg;

    // Width of every period counter seen by management.
    localparam int CNT_W = 32;
    // Lines in the received signal; three for this card.
    localparam int STS_N = 3;
    // Per-frame parity result widths.
    localparam int B1_W = 4;
    localparam int ERR_W = 5;
    // Largest per-frame counts that can be recognised.
    localparam logic [B1_W-1:0] B1_MAX = 4'h8;
    localparam logic [ERR_W-1:0] B2_MAX = ERR_W'(8 * STS_N);
    // Width of the externally supplied severity thresholds.
    localparam int K_W = 20;
    // Width of the current-second violation register.
    localparam int SEC_W = 20;
    // Consecutive seconds that change the availability state.
    localparam int RUN_W = 4;
    localparam logic [RUN_W-1:0] UA_RUN = 4'ha;
    // Width of the unavailable-second increment.
    localparam int ADD_W = 5;
    // Number of ring-type variant counters that stay at zero.
    localparam int NVAR = 6;

    // Line availability states.
    typedef enum logic {
        SLPM_AVAIL,
        SLPM_UNAVAIL
    } slpm_ua_state_t;

endpackage

`default_nettype wire

// ===== inc/slpm_sec_if.sv
// Link between the top block and one per-second accumulator.
`default_nettype none

interface slpm_sec_if;
    logic ce;
    logic tick;
    logic [slpm_pkg::ERR_W-1:0] err;
    logic defect;
    logic [slpm_pkg::K_W-1:0] thresh;
    logic done;
    logic es;
    logic ses;

    // Accumulator side.
    modport acc (
        input ce, tick, err, defect, thresh,
        output done, es, ses
    );
    // Top block side.
    modport user (
        output ce, tick, err, defect, thresh,
        input done, es, ses
    );
    // Availability tracker side.
    modport mon (
        input ce, done, ses
    );
endinterface

`default_nettype wire
